// ---- logic/cmt_txn_mgr.sv ----
// control message transaction manager: register messages, notify transactions, errors
`timescale 1ns/10ps
`include "cmt_consts.svh"
module cmt_txn_mgr #(
  parameter int unsigned REG_WORDS   = 16,
  parameter int unsigned ENTRIES     = 4,
  parameter int unsigned CNT_W       = 32,
  parameter int unsigned NTF_TMO_CYC = (`CMT_NTF_TMO_NS * `CMT_CLK_MHZ + 999) / 1000,
  parameter int unsigned TMO_EXT_CYC = `CMT_TMO_EXT_CYC
) (
  input  logic                          core_clk,
  input  logic                          rst,
  input  logic                          core_ce,
  input  logic                          rx_valid,
  input  cmt_pkg::cmt_msg_t             rx_msg,
  output logic                          rx_ready,
  output logic                          rsp_valid,
  output cmt_pkg::cmt_rsp_t             rsp,
  input  logic                          rsp_ready,
  input  logic                          ntf_req,
  input  logic [cmt_pkg::CMT_SESS_W-1:0] ntf_session,
  input  logic [cmt_pkg::CMT_DATA_W-1:0] ntf_event,
  output logic                          ntf_ack,
  output logic                          ntf_valid,
  output cmt_pkg::cmt_ntf_t             ntf,
  input  logic [cmt_pkg::CMT_NSESS-1:0] sess_lost,
  output logic                          fifo_wr,
  output logic [cmt_pkg::CMT_DATA_W-1:0] fifo_data,
  output logic                          ntf_timeout,
  output logic                          late_rsp,
  output logic [ENTRIES-1:0]            ntf_open,
  output logic [CNT_W-1:0]              tmo_lim
);
  import cmt_pkg::*;
  localparam int unsigned IDX_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
  localparam int unsigned RW_W  = (REG_WORDS > 1) ? $clog2(REG_WORDS) : 1;

  cmt_state_t            st_q;
  cmt_msg_t              m_q;
  cmt_kind_t             kind;
  cmt_rsp_t              rsp_q;
  cmt_ntf_t              ntf_q;
  logic [7:0]            rsp_code;
  logic [7:0]            err_code;
  logic [CMT_DATA_W-1:0] regs_q [REG_WORDS];
  logic [CMT_ADDR_W-1:0] beat_q;
  logic [CMT_ADDR_W-1:0] waddr;
  logic [CMT_TID_W-1:0]  ptid_q;
  logic [CMT_TID_W-1:0]  eff_tid;
  logic [RW_W-1:0]       widx;
  logic [CMT_DATA_W-1:0] wm;
  logic [CMT_DATA_W-1:0] wdata;
  logic [CMT_DATA_W-1:0] mwr_val;
  logic [CMT_DATA_W-1:0] rev;
  logic                  in_rng;
  logic                  lost_now;
  logic                  exec;
  logic                  give_rsp;
  logic                  take;
  logic                  rx_ready_q;
  logic                  rsp_valid_q;
  logic                  fifo_wr_q;
  logic [CMT_DATA_W-1:0] fifo_data_q;
  logic                  ntf_valid_q;
  logic                  ntf_ack_q;
  logic                  ntf_timeout_q;
  logic                  late_q;
  logic [CNT_W-1:0]      tmo_lim_q;
  logic [ENTRIES-1:0]    busy;
  logic [ENTRIES-1:0]    expd;
  logic [IDX_W-1:0]      ridx;
  logic [IDX_W-1:0]      fidx;
  logic [IDX_W-1:0]      aidx;
  logic [CMT_SESS_W-1:0] asess;
  logic [CMT_TID_W-1:0]  tid_q [CMT_NSESS];
  logic [CMT_DATA_W-1:0] ev_q [ENTRIES];
  logic [CMT_SESS_W-1:0] es_q [ENTRIES];
  logic                  retry;
  logic                  new_go;
  logic                  alloc;
  logic                  close;
  logic                  hit;

  function automatic logic [CMT_DATA_W-1:0] width_mask(input logic [1:0] w);
    case (w)
      `CMT_W8:  width_mask = `CMT_MASK8;
      `CMT_W16: width_mask = `CMT_MASK16;
      default:  width_mask = `CMT_MASK32;
    endcase
  endfunction

  function automatic logic [IDX_W-1:0] low_idx(input logic [ENTRIES-1:0] v);
    low_idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      if (v[i])
        low_idx = IDX_W'(i);
    end
  endfunction

  cmt_classify u_cls (
    .code     (m_q.code),
    .kind     (kind),
    .rsp_code (rsp_code),
    .err_code (err_code)
  );

  assign take     = core_ce && rx_valid && rx_ready_q;
  assign exec     = core_ce && st_q == CMT_S_EXEC;
  assign lost_now = sess_lost[m_q.session];
  assign eff_tid  = (m_q.tid != `CMT_TID_IGNORE) ? m_q.tid : ptid_q;
  // fifo mode keeps the address fixed; a plain burst walks one word per beat
  assign waddr    = m_q.fifo_mode ? m_q.addr : CMT_ADDR_W'(m_q.addr + beat_q);
  assign widx     = waddr[RW_W-1:0];
  assign in_rng   = 32'(waddr) < REG_WORDS;
  assign wm       = width_mask(m_q.width);
  assign wdata    = m_q.data & wm;
  // one-cycle merge: no other writer can slip between read and write
  assign mwr_val  = (regs_q[widx] & ~(m_q.mask & wm)) | (wdata & m_q.mask);

  always_comb
  begin
    give_rsp = 1'b0;
    if (m_q.msg_last && !lost_now)
      case (kind)
        CMT_K_REG_XCH, CMT_K_MASK_WR: give_rsp = !m_q.suppress;
        CMT_K_UNSUP:                  give_rsp = 1'b1;
        default:                      give_rsp = 1'b0;
      endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      st_q <= CMT_S_IDLE;
    else if (core_ce)
      case (st_q)
        CMT_S_IDLE: if (take) st_q <= CMT_S_EXEC;
        CMT_S_EXEC: st_q <= give_rsp ? CMT_S_RESP : CMT_S_IDLE;
        CMT_S_RESP: if (rsp_ready || lost_now) st_q <= CMT_S_IDLE;
        default:    st_q <= CMT_S_IDLE;
      endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      rx_ready_q <= 1'b0;
    else if (core_ce)
      case (st_q)
        CMT_S_IDLE: rx_ready_q <= !take;
        CMT_S_EXEC: rx_ready_q <= !give_rsp;
        CMT_S_RESP: rx_ready_q <= rsp_ready || lost_now;
        default:    rx_ready_q <= 1'b0;
      endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      m_q    <= '0;
      ptid_q <= '0;
    end
    else if (take)
    begin
      m_q <= rx_msg;
      if (rx_msg.pkt_first)
        ptid_q <= rx_msg.ptid;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      beat_q <= '0;
    else if (exec)
      beat_q <= m_q.msg_last ? '0 : CMT_ADDR_W'(beat_q + 1'b1);
  end

  for (genvar g = 0; g < REG_WORDS; g++)
  begin : g_reg
    always_ff @(posedge core_clk)
    begin
      if (rst)
        regs_q[g] <= '0;
      else if (exec && in_rng && widx == RW_W'(g))
      begin
        if (kind == CMT_K_MASK_WR)
          regs_q[g] <= mwr_val;
        else if (kind == CMT_K_REG_XCH && m_q.write && !m_q.fifo_mode)
          regs_q[g] <= (regs_q[g] & ~wm) | wdata;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fifo_wr_q   <= 1'b0;
      fifo_data_q <= '0;
    end
    else if (core_ce)
    begin
      fifo_wr_q <= exec && kind == CMT_K_REG_XCH && m_q.write && m_q.fifo_mode;
      if (exec && kind == CMT_K_REG_XCH && m_q.write && m_q.fifo_mode)
        fifo_data_q <= wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
    end
    else if (exec)
    begin
      rsp_valid_q   <= give_rsp;
      rsp_q.session <= m_q.session;
      rsp_q.tid     <= eff_tid;
      if (kind == CMT_K_UNSUP)
      begin
        rsp_q.code <= err_code;
        rsp_q.len  <= `CMT_ERR_LEN;
        rsp_q.ret  <= `CMT_RC_UNSUP;
        rsp_q.data <= '0;
      end
      else
      begin
        rsp_q.code <= rsp_code;
        rsp_q.len  <= (kind == CMT_K_REG_XCH) ? `CMT_REG_XCHG_RSP_LEN : `CMT_MASK_WR_RSP_LEN;
        rsp_q.ret  <= `CMT_RC_OK;
        rsp_q.data <= (kind == CMT_K_REG_XCH && !m_q.write && in_rng) ? regs_q[widx] & wm : '0;
      end
    end
    else if (core_ce && st_q == CMT_S_RESP && (rsp_ready || lost_now))
      rsp_valid_q <= 1'b0;
  end

  // notify side: retry of an expired entry wins over a new request
  assign ridx   = low_idx(expd);
  assign fidx   = low_idx(~busy);
  assign rev    = ev_q[ridx];
  assign retry  = core_ce && (|expd) && !sess_lost[es_q[ridx]];
  assign new_go = core_ce && !retry && ntf_req && !ntf_ack_q && !(&busy) &&
                  !sess_lost[ntf_session];
  assign alloc  = retry || new_go;
  assign aidx   = retry ? ridx : fidx;
  assign asess  = retry ? es_q[ridx] : ntf_session;
  assign close  = exec && kind == CMT_K_NTF_ANS;

  cmt_txn_table #(
    .ENTRIES (ENTRIES),
    .CNT_W   (CNT_W),
    .IDX_W   (IDX_W)
  ) u_tbl (
    .core_clk   (core_clk),
    .rst        (rst),
    .core_ce    (core_ce),
    .alloc      (alloc),
    .alloc_idx  (aidx),
    .alloc_sess (asess),
    .alloc_tid  (tid_q[asess]),
    .close      (close),
    .close_sess (m_q.session),
    .close_tid  (eff_tid),
    .sess_lost  (sess_lost),
    .tmo_lim    (tmo_lim_q),
    .busy       (busy),
    .expd       (expd),
    .hit        (hit)
  );

  for (genvar s = 0; s < CMT_NSESS; s++)
  begin : g_sess
    always_ff @(posedge core_clk)
    begin
      if (rst || (core_ce && sess_lost[s]))
        tid_q[s] <= `CMT_TID_FIRST;
      else if (alloc && asess == CMT_SESS_W'(s))
        tid_q[s] <= (tid_q[s] == '1) ? `CMT_TID_FIRST : tid_q[s] + 1'b1;
    end
  end

  for (genvar e = 0; e < ENTRIES; e++)
  begin : g_pay
    always_ff @(posedge core_clk)
    begin
      if (rst)
      begin
        ev_q[e] <= '0;
        es_q[e] <= '0;
      end
      else if (new_go && fidx == IDX_W'(e))
      begin
        ev_q[e] <= ntf_event;
        es_q[e] <= ntf_session;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ntf_valid_q   <= 1'b0;
      ntf_ack_q     <= 1'b0;
      ntf_timeout_q <= 1'b0;
      ntf_q         <= '0;
    end
    else if (core_ce)
    begin
      ntf_valid_q   <= alloc;
      ntf_ack_q     <= new_go;
      ntf_timeout_q <= retry;
      if (alloc)
      begin
        ntf_q.session <= asess;
        ntf_q.code    <= `CMT_NTF_REQ;
        ntf_q.tid     <= tid_q[asess];
        ntf_q.evt     <= retry ? rev : ntf_event;
      end
    end
  end

  // a late answer means the timeout was too tight, so later waits grow
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      late_q    <= 1'b0;
      tmo_lim_q <= CNT_W'(NTF_TMO_CYC);
    end
    else if (core_ce)
    begin
      late_q <= close && !hit;
      if (close && !hit)
        tmo_lim_q <= (tmo_lim_q > ~CNT_W'(TMO_EXT_CYC)) ? '1 :
                     tmo_lim_q + CNT_W'(TMO_EXT_CYC);
    end
  end

  assign rx_ready    = rx_ready_q;
  assign rsp_valid   = rsp_valid_q;
  assign rsp         = rsp_q;
  assign fifo_wr     = fifo_wr_q;
  assign fifo_data   = fifo_data_q;
  assign ntf_valid   = ntf_valid_q;
  assign ntf         = ntf_q;
  assign ntf_ack     = ntf_ack_q;
  assign ntf_timeout = ntf_timeout_q;
  assign late_rsp    = late_q;
  assign ntf_open    = busy;
  assign tmo_lim     = tmo_lim_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  rsp_code_form_a: assert property (
    rsp_valid_q |-> rsp_q.code[0] && (rsp_q.code[7] == (rsp_q.ret != `CMT_RC_OK)))
    else $error("answer code has wrong request or error bit");
  err_answer_a: assert property (
    exec && kind == CMT_K_UNSUP && m_q.msg_last && !lost_now |=>
    rsp_valid_q && rsp_q.len == `CMT_ERR_LEN && rsp_q.ret == `CMT_RC_UNSUP &&
    rsp_q.code == $past(err_code))
    else $error("unknown message not answered with general error");
  tid_echo_a: assert property (
    rsp_valid_q |-> rsp_q.tid == eff_tid && rsp_q.session == m_q.session)
    else $error("answer identifier differs from request");
  suppress_rsp_a: assert property (
    exec && (kind == CMT_K_REG_XCH || kind == CMT_K_MASK_WR) && m_q.suppress |=> !rsp_valid_q)
    else $error("suppressed request still answered");
  mask_write_a: assert property (
    exec && kind == CMT_K_MASK_WR && in_rng |=> regs_q[$past(widx)] == $past(mwr_val))
    else $error("masked write stored wrong value");
  fifo_word_a: assert property (
    exec && kind == CMT_K_REG_XCH && m_q.write && m_q.fifo_mode |=>
    fifo_wr_q && fifo_data_q == $past(wdata))
    else $error("fifo word not delivered");
  width_data_a: assert property (
    rsp_valid_q && !rsp_q.code[7] |-> (rsp_q.data & ~wm) == '0)
    else $error("read data wider than the declared width");
  fresh_tid_a: assert property (
    ntf_valid_q |-> ntf_q.tid != `CMT_TID_IGNORE && ntf_q.code == `CMT_NTF_REQ)
    else $error("notify issued with reserved identifier");
  retry_reissue_a: assert property (
    retry |=> ntf_valid_q && ntf_timeout_q && !ntf_ack_q && ntf_q.evt == $past(rev))
    else $error("expired notify not reissued");
  late_stretch_a: assert property (
    close && !hit && tmo_lim_q != '1 |=> late_q && tmo_lim_q > $past(tmo_lim_q))
    else $error("late answer did not lengthen timeout");
  lost_drop_a: assert property (
    core_ce && st_q == CMT_S_RESP && lost_now |=> !rsp_valid_q && st_q == CMT_S_IDLE)
    else $error("answer kept for a lost session");
endmodule

// ---- inc/cmt_consts.svh ----
// message codes, answer fields and timing counts of the transaction manager
`ifndef CMT_CONSTS_SVH
`define CMT_CONSTS_SVH
`define CMT_NTF_REQ          8'h02
`define CMT_NTF_RSP          8'h03
`define CMT_NTF_ERR          8'h83
`define CMT_REG_XCHG_REQ     8'h10
`define CMT_MASK_WR_REQ      8'h12
`define CMT_RSP_BIT          8'h01
`define CMT_ERR_MARK         8'h81
`define CMT_ERR_LEN          16'h0003
`define CMT_REG_XCHG_RSP_LEN 16'h000b
`define CMT_MASK_WR_RSP_LEN  16'h0007
`define CMT_RC_OK            8'h00
`define CMT_RC_UNSUP         8'h01
`define CMT_TID_IGNORE       16'h0000
`define CMT_TID_FIRST        16'h0001
`define CMT_W8               2'h0
`define CMT_W16              2'h1
`define CMT_MASK8            32'h000000ff
`define CMT_MASK16           32'h0000ffff
`define CMT_MASK32           32'hffffffff
`define CMT_NTF_TMO_NS       1000000
`define CMT_CLK_MHZ          250
`define CMT_TMO_EXT_CYC      1024
`endif

// ---- inc/cmt_pkg.sv ----
// shared types of the control message transaction manager
package cmt_pkg;
  localparam int unsigned CMT_SESS_W = 2;
  localparam int unsigned CMT_NSESS  = 1 << CMT_SESS_W;
  localparam int unsigned CMT_TID_W  = 16;
  localparam int unsigned CMT_ADDR_W = 16;
  localparam int unsigned CMT_DATA_W = 32;

  typedef enum logic [2:0] {
    CMT_S_IDLE = 3'b001,
    CMT_S_EXEC = 3'b010,
    CMT_S_RESP = 3'b100
  } cmt_state_t;

  typedef enum logic [1:0] {
    CMT_K_UNSUP   = 2'h0,
    CMT_K_REG_XCH = 2'h1,
    CMT_K_MASK_WR = 2'h2,
    CMT_K_NTF_ANS = 2'h3
  } cmt_kind_t;

  typedef struct packed {
    logic [CMT_SESS_W-1:0] session;
    logic [7:0]            code;
    logic [CMT_TID_W-1:0]  tid;
    logic [CMT_TID_W-1:0]  ptid;
    logic                  pkt_first;
    logic                  msg_last;
    logic                  suppress;
    logic                  fifo_mode;
    logic                  write;
    logic [1:0]            width;
    logic [CMT_ADDR_W-1:0] addr;
    logic [CMT_DATA_W-1:0] data;
    logic [CMT_DATA_W-1:0] mask;
  } cmt_msg_t;

  typedef struct packed {
    logic [CMT_SESS_W-1:0] session;
    logic [7:0]            code;
    logic [CMT_TID_W-1:0]  tid;
    logic [15:0]           len;
    logic [7:0]            ret;
    logic [CMT_DATA_W-1:0] data;
  } cmt_rsp_t;

  typedef struct packed {
    logic [CMT_SESS_W-1:0] session;
    logic [7:0]            code;
    logic [CMT_TID_W-1:0]  tid;
    logic [CMT_DATA_W-1:0] evt;
  } cmt_ntf_t;
endpackage

// ---- logic/cmt_classify.sv ----
// message code classifier and answer code builder
`timescale 1ns/10ps
`include "cmt_consts.svh"
module cmt_classify (
  input  logic [7:0]         code,
  output cmt_pkg::cmt_kind_t kind,
  output logic [7:0]         rsp_code,
  output logic [7:0]         err_code
);
  import cmt_pkg::*;
  always_comb
  begin
    rsp_code = code | `CMT_RSP_BIT;
    err_code = code | `CMT_ERR_MARK;
    case (code)
      `CMT_REG_XCHG_REQ: kind = CMT_K_REG_XCH;
      `CMT_MASK_WR_REQ:  kind = CMT_K_MASK_WR;
      `CMT_NTF_RSP,
      `CMT_NTF_ERR:      kind = CMT_K_NTF_ANS;
      default:           kind = CMT_K_UNSUP;
    endcase
  end
endmodule

// ---- logic/cmt_txn_table.sv ----
// table of open slave-initiated transactions, one timer per entry
`timescale 1ns/10ps
`include "cmt_consts.svh"
module cmt_txn_table #(
  parameter int unsigned ENTRIES = 4,
  parameter int unsigned CNT_W   = 32,
  parameter int unsigned IDX_W   = 2
) (
  input  logic                           core_clk,
  input  logic                           rst,
  input  logic                           core_ce,
  input  logic                           alloc,
  input  logic [IDX_W-1:0]               alloc_idx,
  input  logic [cmt_pkg::CMT_SESS_W-1:0] alloc_sess,
  input  logic [cmt_pkg::CMT_TID_W-1:0]  alloc_tid,
  input  logic                           close,
  input  logic [cmt_pkg::CMT_SESS_W-1:0] close_sess,
  input  logic [cmt_pkg::CMT_TID_W-1:0]  close_tid,
  input  logic [cmt_pkg::CMT_NSESS-1:0]  sess_lost,
  input  logic [CNT_W-1:0]               tmo_lim,
  output logic [ENTRIES-1:0]             busy,
  output logic [ENTRIES-1:0]             expd,
  output logic                           hit
);
  import cmt_pkg::*;
  logic [ENTRIES-1:0] m;
  logic [ENTRIES-1:0] msel;

  // an ignored identifier closes only the lowest-indexed open entry of the session
  assign msel = m & (~m + {{(ENTRIES-1){1'b0}}, 1'b1});
  assign hit  = |m;

  for (genvar g = 0; g < ENTRIES; g++)
  begin : g_ent
    logic                  v_q;
    logic [CMT_SESS_W-1:0] s_q;
    logic [CMT_TID_W-1:0]  t_q;
    logic [CNT_W-1:0]      c_q;
    assign busy[g] = v_q;
    assign m[g]    = v_q && s_q == close_sess &&
                     (close_tid == `CMT_TID_IGNORE || t_q == close_tid);
    assign expd[g] = v_q && c_q >= tmo_lim;
    always_ff @(posedge core_clk)
    begin
      if (rst)
      begin
        v_q <= 1'b0;
        s_q <= '0;
        t_q <= '0;
        c_q <= '0;
      end
      else if (core_ce)
      begin
        if (alloc && alloc_idx == IDX_W'(g))
        begin
          v_q <= 1'b1;
          s_q <= alloc_sess;
          t_q <= alloc_tid;
          c_q <= '0;
        end
        else if ((close && msel[g]) || sess_lost[s_q])
          v_q <= 1'b0;
        else if (v_q && !expd[g])
          c_q <= c_q + 1'b1;
      end
    end
    lost_entry_clear_a: assert property (@(posedge core_clk) disable iff (rst)
      core_ce && v_q && sess_lost[s_q] && !(alloc && alloc_idx == IDX_W'(g)) |=> !v_q)
      else $error("entry still open after its session was lost");
  end
endmodule

// ---- logic/cmt_classify_fix.sv ----
// (intentionally empty)

// ---- verif/cmt_master_model.sv ----
// managing master model: takes answers with a chosen lag
`timescale 1ns/10ps
module cmt_master_model (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              rsp_valid,
  input  wire cmt_pkg::cmt_rsp_t rsp,
  input  wire logic [3:0]        lag,
  output logic                   rsp_ready,
  output int                     n_rsp,
  output cmt_pkg::cmt_rsp_t      last
);
  import cmt_pkg::*;
  logic [3:0] cnt_q;
  // lag makes the master slow on purpose; ready held until the handshake edge
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rsp_ready <= 1'b0;
      cnt_q     <= 4'h0;
      n_rsp     <= 0;
    end
    else if (rsp_valid && rsp_ready)
    begin
      rsp_ready <= 1'b0;
      cnt_q     <= 4'h0;
      n_rsp     <= n_rsp + 1;
      last      <= rsp;
    end
    else if (rsp_valid)
    begin
      cnt_q     <= cnt_q + 4'h1;
      rsp_ready <= (cnt_q >= lag);
    end
  end
endmodule

// ---- verif/testbench.sv ----
// self-checking bench of the transaction manager
`timescale 1ns/10ps
module testbench;
  import cmt_pkg::*;
  typedef struct packed {
    logic [7:0]  c;
    logic        w;
    logic [1:0]  wd;
    logic [15:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [7:0]  ec;
    logic [15:0] el;
    logic [7:0]  er;
    logic        rd;
    logic [31:0] ed;
  } cmt_row_t;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic              rx_valid = 1'b0;
  cmt_msg_t          rx_msg = '0;
  logic              rx_ready;
  logic              rsp_valid;
  logic              rsp_ready;
  cmt_rsp_t          rsp;
  cmt_rsp_t          last;
  logic              ntf_req = 1'b0;
  logic [1:0]        ntf_session = 2'h0;
  logic [31:0]       ntf_event = 32'h0;
  logic              ntf_ack;
  logic              ntf_valid;
  cmt_ntf_t          ntf;
  cmt_ntf_t          nt;
  logic [3:0]        sess_lost = 4'h0;
  logic              fifo_wr;
  logic [31:0]       fifo_data;
  logic [31:0]       fd;
  logic              ntf_timeout;
  logic              late_rsp;
  logic [3:0]        ntf_open;
  logic [31:0]       tmo_lim;
  logic [3:0]        lag = 4'h0;
  int                n_rsp;
  int                n_tmo = 0;
  int                n_late = 0;
  int                n_fail = 0;
  int                num_checks = 0;
  int                n0;
  cmt_row_t          rows [10];
  cmt_msg_t          m;
  always #2 core_clk = ~core_clk;
  // short counts keep the run brief; expectations use the same figures
  cmt_txn_mgr #(.NTF_TMO_CYC(20), .TMO_EXT_CYC(4)) uut (
    .core_clk(core_clk), .rst(rst), .core_ce(1'b1), .rx_valid(rx_valid),
    .rx_msg(rx_msg), .rx_ready(rx_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .rsp_ready(rsp_ready), .ntf_req(ntf_req), .ntf_session(ntf_session),
    .ntf_event(ntf_event), .ntf_ack(ntf_ack), .ntf_valid(ntf_valid), .ntf(ntf),
    .sess_lost(sess_lost), .fifo_wr(fifo_wr), .fifo_data(fifo_data),
    .ntf_timeout(ntf_timeout), .late_rsp(late_rsp), .ntf_open(ntf_open),
    .tmo_lim(tmo_lim));
  cmt_master_model partner (
    .core_clk(core_clk), .rst(rst), .rsp_valid(rsp_valid), .rsp(rsp),
    .lag(lag), .rsp_ready(rsp_ready), .n_rsp(n_rsp), .last(last));
  always @(posedge core_clk)
  begin
    if (ntf_valid)
      nt <= ntf;
    if (fifo_wr)
      fd <= fifo_data;
    n_tmo  <= n_tmo + ntf_timeout;
    n_late <= n_late + late_rsp;
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic cmt_msg_t mk(input logic [7:0] c, input logic [15:0] t,
                                  input logic w, input logic [1:0] wd,
                                  input logic [15:0] a, input logic [31:0] d,
                                  input logic [31:0] k);
    cmt_msg_t r;
    r = '0;
    r.code = c;
    r.tid = t;
    r.write = w;
    r.width = wd;
    r.addr = a;
    r.data = d;
    r.mask = k;
    r.pkt_first = 1'b1;
    r.msg_last = 1'b1;
    return r;
  endfunction
  // released message lines show the inverse, never the stale value
  task automatic send(input cmt_msg_t s);
    int k;
    @(posedge core_clk);
    rx_msg <= s;
    rx_valid <= 1'b1;
    k = 0;
    @(negedge core_clk);
    while (rx_ready !== 1'b1 && k < 50)
    begin
      k++;
      @(negedge core_clk);
    end
    if (k >= 50)
      n_fail++;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_msg <= ~s;
  endtask
  task automatic wait_rsp(input int base);
    int k;
    k = 0;
    while (n_rsp == base && k < 60)
    begin
      k++;
      @(negedge core_clk);
    end
    if (k >= 60)
      n_fail++;
  endtask
  task automatic ntf_go(input logic [1:0] s, input logic [31:0] ev);
    int k;
    @(posedge core_clk);
    ntf_req <= 1'b1;
    ntf_session <= s;
    ntf_event <= ev;
    k = 0;
    @(negedge core_clk);
    while (ntf_ack !== 1'b1 && k < 50)
    begin
      k++;
      @(negedge core_clk);
    end
    if (k >= 50)
      n_fail++;
    @(posedge core_clk);
    ntf_req <= 1'b0;
    @(negedge core_clk);
  endtask
  initial
  begin
    #100000;
    n_fail++;
    wrap_up();
  end
  initial
  begin
    rows[0] = '{8'h10, 1, 2, 1, 32'h12345678, 0, 8'h11, 16'h000b, 0, 0, 0};
    rows[1] = '{8'h10, 0, 2, 1, 0, 0, 8'h11, 16'h000b, 0, 1, 32'h12345678};
    rows[2] = '{8'h12, 1, 2, 1, 32'hffffffff, 32'h000000f0, 8'h13, 16'h0007, 0, 0, 0};
    rows[3] = '{8'h10, 0, 0, 1, 0, 0, 8'h11, 16'h000b, 0, 1, 32'h000000f8};
    rows[4] = '{8'h10, 0, 1, 1, 0, 0, 8'h11, 16'h000b, 0, 1, 32'h000056f8};
    rows[5] = '{8'h04, 0, 2, 1, 0, 0, 8'h85, 16'h0003, 1, 0, 0};
    rows[6] = '{8'h06, 0, 2, 1, 0, 0, 8'h87, 16'h0003, 1, 0, 0};
    rows[7] = '{8'h10, 0, 2, 16'h0020, 0, 0, 8'h11, 16'h000b, 0, 1, 0};
    rows[8] = '{8'h12, 1, 0, 1, 0, 32'hffffffff, 8'h13, 16'h0007, 0, 0, 0};
    rows[9] = '{8'h10, 0, 2, 1, 0, 0, 8'h11, 16'h000b, 0, 1, 32'h12345600};
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk(tmo_lim, 32'd20);
    chk({ntf_open, rsp_valid, ntf_valid}, 0);
    $display("test reset done");
    for (int i = 0; i < 10; i++)
    begin
      lag <= {2'b00, i[1:0]};
      n0 = n_rsp;
      send(mk(rows[i].c, 16'(i + 1), rows[i].w, rows[i].wd, rows[i].a, rows[i].d, rows[i].m));
      wait_rsp(n0);
      chk({last.code, last.len, last.ret, last.tid}, {rows[i].ec, rows[i].el, rows[i].er, 16'(i + 1)});
      if (rows[i].rd)
        chk(last.data, rows[i].ed);
    end
    $display("test rows done");
    n0 = n_rsp;
    m = mk(8'h10, 16'h0030, 1, 2, 2, 32'h000000a5, 0);
    m.suppress = 1'b1;
    send(m);
    repeat (6) @(negedge core_clk);
    chk(n_rsp, n0);
    send(mk(8'h10, 16'h0031, 0, 2, 2, 0, 0));
    wait_rsp(n0);
    chk(last.data, 32'h000000a5);
    n0 = n_rsp;
    m = mk(8'h10, 0, 1, 2, 3, 32'hc0ffee01, 0);
    m.fifo_mode = 1'b1;
    m.ptid = 16'h0042;
    send(m);
    wait_rsp(n0);
    chk(fd, 32'hc0ffee01);
    chk(last.tid, 16'h0042);
    // two beats of one packet: second beat leans on the packet identifier
    m = mk(8'h10, 16'h0060, 1, 2, 4, 32'h00000011, 0);
    m.msg_last = 1'b0;
    m.ptid = 16'h0061;
    send(m);
    m = mk(8'h10, 0, 1, 2, 4, 32'h00000022, 0);
    m.pkt_first = 1'b0;
    n0 = n_rsp;
    send(m);
    wait_rsp(n0);
    chk(last.tid, 16'h0061);
    send(mk(8'h10, 16'h0062, 0, 2, 5, 0, 0));
    wait_rsp(n0 + 1);
    chk(last.data, 32'h00000022);
    $display("test suppress fifo done");
    ntf_go(2'h0, 32'h00000011);
    chk({nt.code, nt.tid, nt.evt}, {8'h02, 16'h0001, 32'h00000011});
    send(mk(8'h03, 16'h0001, 0, 2, 0, 0, 0));
    repeat (3) @(negedge core_clk);
    chk(ntf_open, 0);
    ntf_go(2'h0, 32'h00000022);
    chk(nt.tid, 16'h0002);
    repeat (30) @(negedge core_clk);
    chk(n_tmo, 1);
    chk({nt.tid, nt.evt}, {16'h0003, 32'h00000022});
    send(mk(8'h03, 16'h0003, 0, 2, 0, 0, 0));
    repeat (3) @(negedge core_clk);
    chk(ntf_open, 0);
    send(mk(8'h83, 16'h0002, 0, 2, 0, 0, 0));
    repeat (3) @(negedge core_clk);
    chk(n_late, 1);
    chk(tmo_lim, 32'd24);
    $display("test notify done");
    ntf_go(2'h1, 32'h00000033);
    chk({nt.session, nt.tid}, {2'h1, 16'h0001});
    @(posedge core_clk);
    sess_lost <= 4'h2;
    repeat (2) @(posedge core_clk);
    sess_lost <= 4'h0;
    @(negedge core_clk);
    chk(ntf_open, 0);
    ntf_go(2'h1, 32'h00000044);
    chk(nt.tid, 16'h0001);
    // slow master leaves an answer standing when its session drops
    lag <= 4'hf;
    n0 = n_rsp;
    send(mk(8'h10, 16'h0050, 0, 2, 1, 0, 0));
    repeat (2) @(negedge core_clk);
    chk(rsp_valid, 1'b1);
    @(posedge core_clk);
    sess_lost <= 4'h1;
    @(posedge core_clk);
    sess_lost <= 4'h0;
    @(negedge core_clk);
    chk({rsp_valid, rx_ready}, 2'b01);
    chk(n_rsp, n0);
    $display("test session loss done");
    chk(ntf_open, 4'h1);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk({tmo_lim, ntf_open, rsp_valid}, {32'd20, 4'h0, 1'b0});
    $display("test reset again done");
    wrap_up();
  end
endmodule
